// [config_pin_pkg.sv]
// constants and types for the configuration pin control block
package config_pin_pkg;

  // ----------------------------------------------------------------
  // mode select codes (defaults, overridable on the top module)
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CODE_AS_DEF = 2'h0;
  localparam logic [1:0] MODE_CODE_PS_DEF = 2'h1;
  localparam int         MODE_W           = 2;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int         USER_IO_W        = 8;
  localparam int         SYNC_W           = 8;
  localparam logic       CHAIN_OUT_RST    = 1'b1;
  localparam logic       SELECT_RST       = 1'b1;

  // ----------------------------------------------------------------
  // synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int         SY_CHAIN         = 0;
  localparam int         SY_RESTART       = 1;
  localparam int         SY_MODE_LO       = 2;
  localparam int         SY_MODE_HI       = 3;
  localparam int         SY_CLEAR         = 4;
  localparam int         SY_OE            = 5;
  localparam int         SY_PACE          = 6;
  localparam int         SY_PLL_POS       = 7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS    = 10;
  localparam int         SCLK_HALF_NS     = 20;
  localparam int         SCLK_HALF_CYC    = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         PACE_DIV_NS      = 80;
  localparam int         PACE_DIV_CYC     = (PACE_DIV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         INIT_TICKS       = 16;
  localparam int         CNT_W            = 8;

  // ----------------------------------------------------------------
  // control states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET,
    ST_IDLE,
    ST_CONFIG,
    ST_INIT,
    ST_USER
  } cfg_state_e;

endpackage

// [pin_sync.sv]
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // ----------------------------------------------------------------
  // per bit two stage chain
  // ----------------------------------------------------------------
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_q;
    logic stab_q;
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        meta_q <= 1'b0;
        stab_q <= 1'b0;
      end else begin
        meta_q <= async_i[g];
        stab_q <= meta_q;
      end
    end
    assign sync_o[g] = stab_q;
  end

endmodule // pin_sync

// [config_chain_pin_control.sv]
// control of the configuration, chain and global override pins
//
// Overview of operation
// - low chain enable input selects this device
// - chain enable output low after configuration
// - active serial: drive commands on serial output
// - active serial: drive memory select low while configuring
// - passive serial: serial pins become user I/O
// - enabled indicator signals user mode, open drain
// - disabled indicator pin is user I/O
// - optional external clock paces initialization
// - global clear low forces all registers clear
// - global clear high: design clears only, outside reset
// - global output enable low floats all user I/O pins
// - global output enable high: design enables, outside reset
// - mode select pins choose configuration mode
// - first clock pin doubles as pll positive
// - serial clock input passive, output active
// - restart low resets, rising edge starts configuration
`timescale 1ns/1ps
module config_chain_pin_control
  import config_pin_pkg::*;
#(
  parameter logic [1:0] MODE_CODE_AS = MODE_CODE_AS_DEF,
  parameter logic [1:0] MODE_CODE_PS = MODE_CODE_PS_DEF
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic                 chain_enable_in_n_i,
  input  wire logic                 config_restart_n_i,
  input  wire logic [MODE_W-1:0]    config_mode_select_i,
  input  wire logic                 global_clear_override_n_i,
  input  wire logic                 global_output_enable_override_i,
  input  wire logic                 init_pace_clock_i,
  input  wire logic                 pace_clock_use_i,
  input  wire logic                 init_done_use_i,
  input  wire logic                 diff_pll_clock_pos_i,
  input  wire logic                 diff_pll_use_i,
  input  wire logic                 load_done_i,
  input  wire logic                 load_cmd_bit_i,
  input  wire logic                 user_clear_i,
  input  wire logic                 user_cmd_out_i,
  input  wire logic                 user_cmd_oe_i,
  input  wire logic                 user_select_i,
  input  wire logic                 user_select_oe_i,
  input  wire logic                 user_init_done_i,
  input  wire logic                 user_init_done_oe_i,
  input  wire logic [USER_IO_W-1:0] user_io_oe_i,
  output logic                      chain_enable_out_n_o,
  output logic                      serial_cmd_out_o,
  output logic                      serial_cmd_oe_o,
  output logic                      mem_select_n_o,
  output logic                      mem_select_oe_o,
  output logic                      config_serial_clock_o,
  output logic                      config_serial_clock_oe_o,
  output logic                      init_done_o,
  output logic                      init_done_oe_o,
  output logic                      user_mode_o,
  output logic                      config_start_o,
  output logic                      device_reset_o,
  output logic                      reg_clear_o,
  output logic [USER_IO_W-1:0]      io_oe_o,
  output logic                      pll1_pos_o,
  output logic                      global_clk0_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_s;
  logic              ce_s;
  logic              restart_s;
  logic [1:0]        mode_s;
  logic              clear_s;
  logic              goe_s;
  logic              pace_s;
  logic              pll_pos_s;

  pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({diff_pll_clock_pos_i, init_pace_clock_i, global_output_enable_override_i,
               global_clear_override_n_i, config_mode_select_i, config_restart_n_i, chain_enable_in_n_i}),
    .sync_o  (sync_s)
  );

  assign ce_s      = sync_s[SY_CHAIN];
  assign restart_s = sync_s[SY_RESTART];
  assign mode_s    = sync_s[SY_MODE_HI:SY_MODE_LO];
  assign clear_s   = sync_s[SY_CLEAR];
  assign goe_s     = sync_s[SY_OE];
  assign pace_s    = sync_s[SY_PACE];
  assign pll_pos_s = sync_s[SY_PLL_POS];

  // ----------------------------------------------------------------
  // mode latch and pacing
  // ----------------------------------------------------------------
  cfg_state_e       state_q;
  logic             mode_as_q;
  logic             mode_ps_q;
  logic             pace_prev_q;
  logic [CNT_W-1:0] div_q;
  logic [CNT_W-1:0] init_cnt_q;
  logic [CNT_W-1:0] sclk_cnt_q;
  logic             sclk_q;
  logic             div_tick;
  logic             pace_tick;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_as_q <= 1'b0;
      mode_ps_q <= 1'b0;
    end else if (state_q == ST_RESET && restart_s) begin
      mode_as_q <= (mode_s == MODE_CODE_AS);
      mode_ps_q <= (mode_s == MODE_CODE_PS);
    end
  end

  assign div_tick = (div_q == CNT_W'(PACE_DIV_CYC - 1));

  always_ff @(posedge clock_i) begin
    if (rst_i || div_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pace_prev_q <= 1'b0;
    end else begin
      pace_prev_q <= pace_s;
    end
  end

  assign pace_tick = pace_clock_use_i ? (pace_s & ~pace_prev_q) : div_tick;

  // ----------------------------------------------------------------
  // configuration sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q    <= ST_RESET;
      init_cnt_q <= '0;
    end else if (!restart_s) begin
      state_q    <= ST_RESET;
      init_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          if (!ce_s) begin
            state_q <= ST_CONFIG;
          end
        end
        ST_CONFIG: begin
          if (ce_s) begin
            state_q <= ST_IDLE;
          end else if (load_done_i) begin
            state_q    <= ST_INIT;
            init_cnt_q <= '0;
          end
        end
        ST_INIT: begin
          if (pace_tick) begin
            if (init_cnt_q == CNT_W'(INIT_TICKS - 1)) begin
              state_q <= ST_USER;
            end
            init_cnt_q <= init_cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= ST_USER;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial clock generation
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i || state_q != ST_CONFIG || !mode_as_q) begin
      sclk_cnt_q <= '0;
      sclk_q     <= 1'b0;
    end else if (sclk_cnt_q == CNT_W'(SCLK_HALF_CYC - 1)) begin
      sclk_cnt_q <= '0;
      sclk_q     <= ~sclk_q;
    end else begin
      sclk_cnt_q <= sclk_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  logic io_free;
  assign io_free = (state_q != ST_RESET) && goe_s;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      chain_enable_out_n_o     <= CHAIN_OUT_RST;
      user_mode_o              <= 1'b0;
      config_start_o           <= 1'b0;
      device_reset_o           <= 1'b1;
    end else begin
      chain_enable_out_n_o     <= !(state_q == ST_INIT || state_q == ST_USER);
      user_mode_o              <= (state_q == ST_USER);
      config_start_o           <= (state_q == ST_RESET) && restart_s;
      device_reset_o           <= (state_q == ST_RESET);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      serial_cmd_out_o         <= 1'b0;
      serial_cmd_oe_o          <= 1'b0;
      mem_select_n_o           <= SELECT_RST;
      mem_select_oe_o          <= 1'b0;
      config_serial_clock_o    <= 1'b0;
      config_serial_clock_oe_o <= 1'b0;
    end else if (mode_as_q && state_q != ST_RESET) begin
      serial_cmd_out_o         <= (state_q == ST_CONFIG) ? load_cmd_bit_i : 1'b0;
      serial_cmd_oe_o          <= 1'b1;
      mem_select_n_o           <= (state_q != ST_CONFIG);
      mem_select_oe_o          <= 1'b1;
      config_serial_clock_o    <= sclk_q;
      config_serial_clock_oe_o <= 1'b1;
    end else begin
      serial_cmd_out_o         <= user_cmd_out_i;
      serial_cmd_oe_o          <= mode_ps_q && io_free && user_cmd_oe_i;
      mem_select_n_o           <= user_select_i;
      mem_select_oe_o          <= mode_ps_q && io_free && user_select_oe_i;
      config_serial_clock_o    <= 1'b0;
      config_serial_clock_oe_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      init_done_o    <= 1'b0;
      init_done_oe_o <= 1'b0;
    end else if (init_done_use_i) begin
      // open drain low until user mode
      init_done_o    <= 1'b0;
      init_done_oe_o <= (state_q != ST_USER);
    end else begin
      init_done_o    <= user_init_done_i;
      init_done_oe_o <= io_free && user_init_done_oe_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reg_clear_o <= 1'b1;
      io_oe_o     <= '0;
    end else begin
      reg_clear_o <= !clear_s || (state_q == ST_RESET) || user_clear_i;
      io_oe_o     <= io_free ? user_io_oe_i : '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pll1_pos_o    <= 1'b0;
      global_clk0_o <= 1'b0;
    end else begin
      pll1_pos_o    <= diff_pll_use_i ? pll_pos_s : 1'b0;
      global_clk0_o <= diff_pll_use_i ? 1'b0 : pll_pos_s;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_chain_low;
    @(posedge clock_i) disable iff (rst_i) (state_q == ST_USER) |=> !chain_enable_out_n_o;
  endproperty
  a_chain_low: assert property (p_chain_low) else $error("chain output not low after config");

  property p_chain_high;
    @(posedge clock_i) disable iff (rst_i) (state_q inside {ST_RESET, ST_IDLE, ST_CONFIG}) |=> chain_enable_out_n_o;
  endproperty
  a_chain_high: assert property (p_chain_high) else $error("chain output low too early");

  property p_select;
    @(posedge clock_i) disable iff (rst_i)
      (state_q == ST_CONFIG && mode_as_q && restart_s) |=> (!mem_select_n_o && mem_select_oe_o);
  endproperty
  a_select: assert property (p_select) else $error("memory not selected in active serial");

  property p_cmd;
    @(posedge clock_i) disable iff (rst_i)
      (state_q == ST_CONFIG && mode_as_q) |=> (serial_cmd_out_o == $past(load_cmd_bit_i)) && serial_cmd_oe_o;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command bit not driven");

  property p_ps_release;
    @(posedge clock_i) disable iff (rst_i)
      (!mode_as_q && mode_ps_q && io_free) |=> (serial_cmd_oe_o == $past(user_cmd_oe_i));
  endproperty
  a_ps_release: assert property (p_ps_release) else $error("serial output not released");

  property p_init_ind;
    @(posedge clock_i) disable iff (rst_i)
      (init_done_use_i && state_q != ST_USER) |=> (init_done_oe_o && !init_done_o);
  endproperty
  a_init_ind: assert property (p_init_ind) else $error("indicator not pulled low");

  property p_clear_force;
    @(posedge clock_i) disable iff (rst_i) !clear_s |=> reg_clear_o;
  endproperty
  a_clear_force: assert property (p_clear_force) else $error("clear not forced");

  property p_clear_pass;
    @(posedge clock_i) disable iff (rst_i)
      (clear_s && state_q != ST_RESET) |=> (reg_clear_o == $past(user_clear_i));
  endproperty
  a_clear_pass: assert property (p_clear_pass) else $error("clear not from design");

  property p_float;
    @(posedge clock_i) disable iff (rst_i) !goe_s |=> (io_oe_o == '0);
  endproperty
  a_float: assert property (p_float) else $error("pins not floated");

  property p_start;
    @(posedge clock_i) disable iff (rst_i)
      (state_q == ST_RESET && restart_s) |=> config_start_o ##1 !config_start_o;
  endproperty
  a_start: assert property (p_start) else $error("start pulse wrong");

  property p_enable;
    @(posedge clock_i) disable iff (rst_i)
      (state_q == ST_IDLE && !ce_s && restart_s) |=> (state_q == ST_CONFIG);
  endproperty
  a_enable: assert property (p_enable) else $error("enabled device not configuring");

  property p_user_reach;
    @(posedge clock_i) disable iff (rst_i)
      (state_q == ST_CONFIG && load_done_i && !ce_s && restart_s) |=>
        (state_q == ST_INIT) ##1 (state_q == ST_INIT || !$past(restart_s));
  endproperty
  a_user_reach: assert property (p_user_reach) else $error("init phase skipped");

  c_as_config: cover property (@(posedge clock_i) disable iff (rst_i) state_q == ST_CONFIG && mode_as_q);
  c_ps_user: cover property (@(posedge clock_i) disable iff (rst_i) state_q == ST_USER && mode_ps_q);
  c_restart: cover property (@(posedge clock_i) disable iff (rst_i) state_q == ST_USER ##1 state_q == ST_RESET);

endmodule // config_chain_pin_control

// [serial_mem_model.sv]
// behavioural serial configuration memory and downstream chain neighbour
`timescale 1ns/1ps
module serial_mem_model #(
  parameter int LOAD_BITS = 16
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic mem_select_n_i,
  input  wire logic mem_select_oe_i,
  input  wire logic serial_clock_i,
  input  wire logic serial_clock_oe_i,
  input  wire logic chain_enable_out_n_i,
  output logic      load_done_o,
  output logic      next_enable_n_o
);
  logic       sclk_q;
  logic [7:0] bits_q;

  // ----------------------------------------------------------------
  // memory: count bits clocked while selected
  // ----------------------------------------------------------------
  // select low enables
  always_ff @(posedge clock_i) begin
    if (rst_i || !mem_select_oe_i || mem_select_n_i) begin
      bits_q      <= 8'h00;
      load_done_o <= 1'b0;
    end else if (serial_clock_oe_i && serial_clock_i && !sclk_q) begin
      bits_q <= bits_q + 8'h01;
      if (bits_q == 8'(LOAD_BITS - 1)) begin
        load_done_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    sclk_q <= serial_clock_oe_i & serial_clock_i;
  end

  // ----------------------------------------------------------------
  // downstream device
  // ----------------------------------------------------------------
  // chain output feeds next
  assign next_enable_n_o = chain_enable_out_n_i;
endmodule // serial_mem_model

// [tb_top.sv]
// self-checking testbench for the configuration pin control block
`timescale 1ns/1ps
module tb_top;
  import config_pin_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic chain_in_n = 1'b1, restart_n = 1'b0, clear_n = 1'b1, oe_ovr = 1'b1;
  logic [1:0] mode_sel = MODE_CODE_AS_DEF;
  logic pace = 1'b0, pace_use = 1'b0, ind_use = 1'b0, pll_in = 1'b0, pll_use = 1'b0;
  logic tb_done = 1'b0, cmd_bit = 1'b0, u_clear = 1'b0, u_cmd = 1'b0, u_cmd_oe = 1'b0;
  logic u_sel = 1'b0, u_sel_oe = 1'b0, u_ind = 1'b0, u_ind_oe = 1'b0;
  logic [7:0] u_io_oe = 8'h00;
  logic chain_out_n, cmd_o, cmd_oe, sel_n, sel_oe, sclk, sclk_oe, ind_o, ind_oe;
  logic user_mode, start, dev_rst, clr, pll_o, gclk_o, mem_done, next_en_n;
  logic [7:0] io_oe;
  int bad_count = 0;
  int checks = 0;

  always #5 clock_i = ~clock_i;

  config_chain_pin_control DUT (
    .clock_i(clock_i), .rst_i(rst_i), .chain_enable_in_n_i(chain_in_n),
    .config_restart_n_i(restart_n), .config_mode_select_i(mode_sel),
    .global_clear_override_n_i(clear_n), .global_output_enable_override_i(oe_ovr),
    .init_pace_clock_i(pace), .pace_clock_use_i(pace_use), .init_done_use_i(ind_use),
    .diff_pll_clock_pos_i(pll_in), .diff_pll_use_i(pll_use), .load_done_i(mem_done | tb_done),
    .load_cmd_bit_i(cmd_bit), .user_clear_i(u_clear), .user_cmd_out_i(u_cmd),
    .user_cmd_oe_i(u_cmd_oe), .user_select_i(u_sel), .user_select_oe_i(u_sel_oe),
    .user_init_done_i(u_ind), .user_init_done_oe_i(u_ind_oe), .user_io_oe_i(u_io_oe),
    .chain_enable_out_n_o(chain_out_n), .serial_cmd_out_o(cmd_o), .serial_cmd_oe_o(cmd_oe),
    .mem_select_n_o(sel_n), .mem_select_oe_o(sel_oe), .config_serial_clock_o(sclk),
    .config_serial_clock_oe_o(sclk_oe), .init_done_o(ind_o), .init_done_oe_o(ind_oe),
    .user_mode_o(user_mode), .config_start_o(start), .device_reset_o(dev_rst),
    .reg_clear_o(clr), .io_oe_o(io_oe), .pll1_pos_o(pll_o), .global_clk0_o(gclk_o));

  serial_mem_model #(.LOAD_BITS(16)) MEM (
    .clock_i(clock_i), .rst_i(rst_i), .mem_select_n_i(sel_n), .mem_select_oe_i(sel_oe),
    .serial_clock_i(sclk), .serial_clock_oe_i(sclk_oe), .chain_enable_out_n_i(chain_out_n),
    .load_done_o(mem_done), .next_enable_n_o(next_en_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic timeout();
    bad_count++;
    $display("Error t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    finish_test();
  endtask

  task automatic restart_rise();
    int i;
    restart_n = 1'b1;
    for (i = 0; i < 12 && start !== 1'b1; i++) cyc(1);
    if (start !== 1'b1) timeout();
    cyc(1);
  endtask

  task automatic wait_user();
    int i;
    for (i = 0; i < 400 && user_mode !== 1'b1; i++) cyc(1);
    if (user_mode !== 1'b1) timeout();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_refuse();
    restart_rise();
    chk(dev_rst, 1'b0);
    cyc(10);
    chk(sel_n, 1'b1);
    chk(chain_out_n, 1'b1);
    chk(next_en_n, 1'b1);
  endtask

  task automatic t_active();
    int i;
    int j;
    logic [7:0] pat;
    logic s0;
    pat = 8'hb4;
    chain_in_n = 1'b0;
    cyc(6);
    chk(sel_n, 1'b0);
    chk(sel_oe, 1'b1);
    chk(cmd_oe, 1'b1);
    chk(sclk_oe, 1'b1);
    chk({ind_oe, ind_o}, 2'b10);
    chk(chain_out_n, 1'b1);
    for (i = 0; i < 8; i++) begin
      cmd_bit = pat[i];
      cyc(1);
      chk(cmd_o, pat[i]);
      if (i == 0) s0 = sclk;
      if (i == SCLK_HALF_CYC) chk(sclk, !s0);
    end
    for (j = 0; j < 200 && chain_out_n !== 1'b0; j++) cyc(1);
    chk(chain_out_n, 1'b0);
    chk(next_en_n, 1'b0);
    wait_user();
    cyc(2);
    chk(ind_oe, 1'b0);
  endtask

  task automatic t_override();
    clear_n = 1'b0;
    cyc(5);
    chk(clr, 1'b1);
    clear_n = 1'b1;
    cyc(5);
    chk(clr, 1'b0);
    u_clear = 1'b1;
    cyc(5);
    chk(clr, 1'b1);
    u_clear = 1'b0;
    u_io_oe = 8'ha5;
    cyc(5);
    chk(io_oe, 8'ha5);
    oe_ovr = 1'b0;
    cyc(5);
    chk(io_oe, 8'h00);
    oe_ovr = 1'b1;
    cyc(5);
    chk(io_oe, 8'ha5);
  endtask

  task automatic t_pll();
    pll_use = 1'b1;
    pll_in = 1'b1;
    cyc(5);
    chk(pll_o, 1'b1);
    chk(gclk_o, 1'b0);
    pll_use = 1'b0;
    pll_in = 1'b0;
    cyc(3);
    pll_in = 1'b1;
    cyc(5);
    chk(gclk_o, 1'b1);
    chk(pll_o, 1'b0);
  endtask

  task automatic t_passive();
    int i;
    restart_n = 1'b0;
    cyc(6);
    chk(dev_rst, 1'b1);
    chk(io_oe, 8'h00);
    chk(chain_out_n, 1'b1);
    mode_sel = MODE_CODE_PS_DEF;
    ind_use = 1'b0;
    pace_use = 1'b1;
    {u_cmd, u_cmd_oe, u_sel, u_sel_oe, u_ind, u_ind_oe} = 6'b110101;
    restart_rise();
    cyc(6);
    chk({cmd_oe, cmd_o, sel_oe, sel_n}, 4'b1110);
    chk(sclk_oe, 1'b0);
    chk(ind_oe, 1'b1);
    tb_done = 1'b1;
    cyc(1);
    tb_done = 1'b0;
    cyc(6);
    for (i = 0; i < 15; i++) begin
      pace = 1'b1;
      cyc(4);
      pace = 1'b0;
      cyc(4);
    end
    cyc(6);
    chk(user_mode, 1'b0);
    pace = 1'b1;
    cyc(8);
    chk(user_mode, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(6);
    rst_i = 1'b0;
    cyc(1);
    t_refuse();
    ind_use = 1'b1;
    t_active();
    t_override();
    t_pll();
    t_passive();
    finish_test();
  end
endmodule // tb_top
